// >>> core/entry_pkg.sv
package entry_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FLD_W  = 6;

    localparam logic [7:0] KEY_MENU    = 8'hE3;
    localparam logic [7:0] KEY_UP      = 8'hE4;
    localparam logic [7:0] KEY_DOWN    = 8'hE5;
    localparam logic [7:0] KEY_BUZ     = 8'hE6;
    localparam logic [7:0] KEY_D0      = 8'hE7;
    localparam logic [7:0] KEY_D9      = 8'hF0;
    localparam logic [7:0] KEY_HA      = 8'hF1;
    localparam logic [7:0] KEY_HF      = 8'hF6;
    localparam logic [7:0] KEY_WIPE    = 8'hF7;
    localparam logic [7:0] KEY_SIGN    = 8'hF8;
    localparam logic [7:0] KEY_POINT   = 8'hF9;
    localparam logic [7:0] KEY_HOME    = 8'hFA;
    localparam logic [7:0] KEY_PUP     = 8'hFB;
    localparam logic [7:0] KEY_PDOWN   = 8'hFC;
    localparam logic [7:0] KEY_CONFIRM = 8'hFF;

    localparam logic [FLD_W-1:0] MAX_FIELDS = 6'd50;
    localparam logic [2:0]       FRAC_POS   = 3'd7;
    localparam logic [2:0]       FRAC_NEG   = 3'd6;
    localparam logic [2:0]       SIGN_DIGIT = 3'd7;
    localparam logic [3:0]       DEC_MAX    = 4'h9;
    localparam logic [3:0]       HEX_MAX    = 4'hF;

    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_FCNT   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_SEL    = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ATTR   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_UPPER  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LOWER  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_OWNER  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
    localparam logic [ADDR_W-1:0] OFS_BUF    = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_TBL    = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_TBLNEG = 8'h28;

    localparam int unsigned CTRL_VER5   = 0;
    localparam int unsigned CTRL_LIM_EN = 1;
    localparam int unsigned CTRL_SYSPAD = 2;
    localparam int unsigned CTRL_BUZ_EN = 3;
    localparam int unsigned CTRL_UP_NEG = 4;
    localparam int unsigned CTRL_LO_NEG = 5;

    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [31:0] LIMIT_RST = 32'h0000_0000;

    typedef struct packed {
        logic       point;
        logic       thumb;
        logic       sgn;
        logic       hex;
    } attr_s;

    typedef struct packed {
        logic       neg;
        logic [31:0] mag;
    } val_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] num;
    } key_ev_s;

    typedef struct packed {
        logic       valid;
        logic [2:0] digit;
        logic       up;
    } wheel_ev_s;

    typedef struct packed {
        logic             valid;
        logic [FLD_W-1:0] field;
        val_s             val;
    } rpt_s;

endpackage

// >>> core/entry_range_check.sv
`timescale 1ns/10ps
module entry_range_check
    import entry_pkg::*;
(
    input  val_s       v,
    input  val_s       hi,
    input  val_s       lo,
    output logic       ok
);
    // Sign-magnitude order; BCD nibbles order like plain binary
    function automatic logic le(val_s a, val_s b);
        if (a.neg != b.neg) begin
            le = a.neg;
        end else if (a.neg) begin
            le = a.mag >= b.mag;
        end else begin
            le = a.mag <= b.mag;
        end
    endfunction

    assign ok = le(lo, v) && le(v, hi);
endmodule // entry_range_check

// >>> core/numeric_entry_key_handler.sv
`timescale 1ns/10ps
module numeric_entry_key_handler
    import entry_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [31:0]       wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic [31:0]            rdata,
    input  wire key_ev_s           key_in,
    input  wire wheel_ev_s         tw_in,
    input  wire logic              buz_start,
    output key_ev_s                sw_rpt,
    output rpt_s                   rpt,
    output logic                   menu_open,
    output logic                   buzzer_on,
    output logic                   keypad_show
);
    logic [7:0]       ctrl_r;
    logic [FLD_W-1:0] fcnt_r, sel_r, cur_r, cur_nxt;
    logic [3:0]       owner_r;
    logic [31:0]      up_r, lo_r, rdata_r;
    attr_s            attr_m [MAX_FIELDS];
    val_s             tbl_m  [MAX_FIELDS];
    val_s             buf_r, buf_nxt, cur_tbl, tw_val, chk_in, up_v, lo_v;
    logic [2:0]       frac_r, frac_nxt, frac_lim;
    logic             in_frac_r, in_frac_nxt;
    logic             buzzer_r, menu_r, show_r;
    key_ev_s          sw_rpt_r;
    rpt_s             rpt_r, rpt_nxt;
    logic             tbl_we;

    function automatic logic [31:0] put_nib(logic [31:0] m, logic [2:0] i,
                                            logic [3:0] n);
        put_nib = m;
        put_nib[{i, 2'b00} +: 4] = n;
    endfunction

    function automatic logic in_rng(logic [7:0] k, logic [7:0] a,
                                    logic [7:0] b);
        in_rng = (k >= a) && (k <= b);
    endfunction

    // Key decode
    wire       kv       = key_in.valid;
    wire       is_sys   = kv && (key_in.num >= KEY_MENU);
    wire       is_dig   = kv && in_rng(key_in.num, KEY_D0, KEY_D9);
    wire       is_hexd  = kv && in_rng(key_in.num, KEY_HA, KEY_HF);
    wire [3:0] dval     = 4'(key_in.num - KEY_D0);
    wire       k_up     = kv && (key_in.num == KEY_UP
                                 || key_in.num == KEY_PUP);
    wire       k_down   = kv && (key_in.num == KEY_DOWN
                                 || key_in.num == KEY_PDOWN);
    wire       k_home   = kv && key_in.num == KEY_HOME;
    wire       k_wipe   = kv && key_in.num == KEY_WIPE;
    wire       k_sign   = kv && key_in.num == KEY_SIGN;
    wire       k_point  = kv && key_in.num == KEY_POINT;
    wire       k_conf   = kv && key_in.num == KEY_CONFIRM;

    wire attr_s cur_attr = attr_m[cur_r];
    wire        owned    = owner_r != 4'h0;
    wire        fld_ok   = owned && fcnt_r != '0 && cur_r < fcnt_r;
    // Numeric keys never drive a thumbwheel field
    wire        entry_ok = fld_ok && !cur_attr.thumb;
    wire        tw_act   = tw_in.valid && fld_ok && cur_attr.thumb
                           && ctrl_r[CTRL_VER5];
    wire        lim_act  = ctrl_r[CTRL_VER5] && ctrl_r[CTRL_LIM_EN];
    wire        dig_ok   = entry_ok && (is_dig
                           || (is_hexd && cur_attr.hex));
    wire        conf_act = entry_ok && k_conf && !tw_act;
    logic       rng_ok;

    assign cur_tbl  = tbl_m[cur_r];
    assign frac_lim = buf_r.neg ? FRAC_NEG : FRAC_POS;
    assign up_v     = '{neg: ctrl_r[CTRL_UP_NEG], mag: up_r};
    assign lo_v     = '{neg: ctrl_r[CTRL_LO_NEG], mag: lo_r};

    // Thumbwheel step on the stored value of the current field
    wire [3:0] tw_old = cur_tbl.mag[{tw_in.digit, 2'b00} +: 4];
    wire [3:0] tw_max = cur_attr.hex ? HEX_MAX : DEC_MAX;
    wire [3:0] tw_new = tw_in.up ? ((tw_old == tw_max) ? 4'h0 : tw_old + 4'h1)
                                 : ((tw_old == 4'h0) ? tw_max : tw_old - 4'h1);
    wire       tw_sgn = cur_attr.sgn && !cur_attr.hex
                        && tw_in.digit == SIGN_DIGIT;
    assign tw_val = tw_sgn ? '{neg: !cur_tbl.neg, mag: cur_tbl.mag}
                           : '{neg: cur_tbl.neg,
                               mag: put_nib(cur_tbl.mag, tw_in.digit,
                                            tw_new)};
    // A sign digit keeps the top nibble free, so seven digits remain
    wire       tw_cap = cur_attr.sgn && tw_val.mag[31:28] != 4'h0;

    assign chk_in = tw_act ? tw_val : buf_r;

    entry_range_check u_chk (
        .v  (chk_in),
        .hi (up_v),
        .lo (lo_v),
        .ok (rng_ok)
    );

    wire tw_good = !tw_cap && (!lim_act || rng_ok);

    // Field selection, wrapping over the fields in creation order
    wire [FLD_W-1:0] last_f = FLD_W'(fcnt_r - 6'd1);
    always_comb begin
        cur_nxt = cur_r;
        if (fld_ok && !tw_act) begin
            if (k_home) begin
                cur_nxt = '0;
            end else if (k_up) begin
                cur_nxt = (cur_r == last_f) ? '0 : FLD_W'(cur_r + 6'd1);
            end else if (k_down) begin
                cur_nxt = (cur_r == '0) ? last_f : FLD_W'(cur_r - 6'd1);
            end
        end
    end
    wire sel_chg = cur_nxt != cur_r;

    // Entry buffer
    always_comb begin
        buf_nxt     = buf_r;
        frac_nxt    = frac_r;
        in_frac_nxt = in_frac_r;
        rpt_nxt     = '0;
        tbl_we      = 1'b0;
        if (tw_act) begin
            rpt_nxt.valid = 1'b1;
            rpt_nxt.field = cur_r;
            if (tw_good) begin
                tbl_we      = 1'b1;
                rpt_nxt.val = tw_val;
                buf_nxt     = tw_val;
            end else begin
                rpt_nxt.val = cur_tbl;
                buf_nxt     = cur_tbl;
            end
        end else if (sel_chg) begin
            buf_nxt     = tbl_m[cur_nxt];
            frac_nxt    = 3'd0;
            in_frac_nxt = 1'b0;
        end else if (dig_ok) begin
            // Oldest digit drops off the top
            buf_nxt.mag = {buf_r.mag[27:0], dval};
            if (buf_r.neg) begin
                buf_nxt.mag[31:28] = 4'h0;
            end
            if (in_frac_r && frac_r < frac_lim) begin
                frac_nxt = frac_r + 3'd1;
            end
        end else if (entry_ok && k_wipe) begin
            buf_nxt     = '0;
            frac_nxt    = 3'd0;
            in_frac_nxt = 1'b0;
        end else if (entry_ok && k_sign && cur_attr.sgn && !cur_attr.hex) begin
            buf_nxt.neg = !buf_r.neg;
            if (!buf_r.neg) begin
                buf_nxt.mag[31:28] = 4'h0;
                if (frac_r > FRAC_NEG) begin
                    frac_nxt = FRAC_NEG;
                end
            end
        end else if (entry_ok && k_point && cur_attr.point) begin
            in_frac_nxt = 1'b1;
        end else if (conf_act) begin
            frac_nxt    = 3'd0;
            in_frac_nxt = 1'b0;
            if (lim_act && !rng_ok) begin
                buf_nxt = cur_tbl;
            end else begin
                tbl_we        = 1'b1;
                rpt_nxt.valid = 1'b1;
                rpt_nxt.field = cur_r;
                rpt_nxt.val   = buf_r;
            end
        end
    end

    // Register port
    wire w_ctrl  = wr && addr == OFS_CTRL;
    wire w_fcnt  = wr && addr == OFS_FCNT;
    wire w_sel   = wr && addr == OFS_SEL;
    wire w_attr  = wr && addr == OFS_ATTR;
    wire w_up    = wr && addr == OFS_UPPER;
    wire w_lo    = wr && addr == OFS_LOWER;
    wire w_owner = wr && addr == OFS_OWNER;
    wire w_tbl   = wr && addr == OFS_TBL;
    wire w_tneg  = wr && addr == OFS_TBLNEG;
    wire [FLD_W-1:0] fcnt_w = (wdata > 32'(MAX_FIELDS)) ? MAX_FIELDS
                                                        : wdata[FLD_W-1:0];
    wire [FLD_W-1:0] sel_w  = (wdata < 32'(MAX_FIELDS))
                              ? wdata[FLD_W-1:0] : '0;
    wire sel_ok = sel_r < MAX_FIELDS;
    // A screen claims entry only while no other screen holds it
    wire owner_take = w_owner && (!owned || wdata[3:0] == 4'h0);

    logic [31:0] rmux;
    always_comb begin
        unique case (addr)
            OFS_CTRL:   rmux = {24'h0000_00, ctrl_r};
            OFS_FCNT:   rmux = {26'h000_0000, fcnt_r};
            OFS_SEL:    rmux = {26'h000_0000, sel_r};
            OFS_ATTR:   rmux = {28'h000_0000, attr_m[sel_r]};
            OFS_UPPER:  rmux = up_r;
            OFS_LOWER:  rmux = lo_r;
            OFS_OWNER:  rmux = {28'h000_0000, owner_r};
            OFS_STATUS: rmux = {16'h0000, buf_r.neg, in_frac_r, buzzer_r,
                                frac_r, 4'h0, cur_r};
            OFS_BUF:    rmux = buf_r.mag;
            OFS_TBL:    rmux = tbl_m[sel_r].mag;
            OFS_TBLNEG: rmux = {31'h0000_0000, tbl_m[sel_r].neg};
            default:    rmux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ctrl_r  <= CTRL_RST;
            fcnt_r  <= '0;
            sel_r   <= '0;
            owner_r <= 4'h0;
            up_r    <= LIMIT_RST;
            lo_r    <= LIMIT_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rd ? rmux : 32'h0000_0000;
            if (w_ctrl)     ctrl_r  <= wdata[7:0];
            if (w_fcnt)     fcnt_r  <= fcnt_w;
            if (w_sel)      sel_r   <= sel_w;
            if (w_up)       up_r    <= wdata;
            if (w_lo)       lo_r    <= wdata;
            if (owner_take) owner_r <= wdata[3:0];
        end
    end

    // Entry writes win over a bus write in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < int'(MAX_FIELDS); i++) begin
                attr_m[i] <= '0;
                tbl_m[i]  <= '0;
            end
        end else begin
            if (w_attr && sel_ok) attr_m[sel_r] <= wdata[3:0];
            if (tbl_we) begin
                tbl_m[cur_r] <= rpt_nxt.val;
            end else if (w_tbl && sel_ok) begin
                tbl_m[sel_r].mag <= wdata;
            end else if (w_tneg && sel_ok) begin
                tbl_m[sel_r].neg <= wdata[0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cur_r     <= '0;
            buf_r     <= '0;
            frac_r    <= 3'd0;
            in_frac_r <= 1'b0;
            rpt_r     <= '0;
        end else begin
            cur_r     <= w_fcnt ? '0 : cur_nxt;
            buf_r     <= buf_nxt;
            frac_r    <= frac_nxt;
            in_frac_r <= in_frac_nxt;
            rpt_r     <= rpt_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            buzzer_r <= 1'b0;
            menu_r   <= 1'b0;
            sw_rpt_r <= '0;
            show_r   <= 1'b0;
        end else begin
            // A new buzzer request beats a same-cycle stop
            if (buz_start && ctrl_r[CTRL_BUZ_EN]) begin
                buzzer_r <= 1'b1;
            end else if (kv && key_in.num == KEY_BUZ) begin
                buzzer_r <= 1'b0;
            end
            menu_r         <= kv && key_in.num == KEY_MENU;
            sw_rpt_r.valid <= kv && !is_sys;
            sw_rpt_r.num   <= key_in.num;
            show_r         <= ctrl_r[CTRL_SYSPAD] && owned
                              && fcnt_r != '0;
        end
    end

    assign rdata       = rdata_r;
    assign sw_rpt      = sw_rpt_r;
    assign rpt         = rpt_r;
    assign menu_open   = menu_r;
    assign buzzer_on   = buzzer_r;
    assign keypad_show = show_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    sequence confirm_press;
        conf_act && !sel_chg && !dig_ok;
    endsequence
    sequence confirm_pass;
        confirm_press ##0 (!lim_act || rng_ok);
    endsequence

    menu_key_a: assert property (kv && key_in.num == KEY_MENU |=> menu_open)
        else $error("menu key did not open the menu");
    sys_silent_a: assert property (is_sys |=> !sw_rpt.valid)
        else $error("system key was reported");
    buzz_stop_a: assert property (kv && key_in.num == KEY_BUZ
        && !(buz_start && ctrl_r[CTRL_BUZ_EN]) |=> !buzzer_on)
        else $error("buzzer kept sounding after stop key");
    confirm_rpt_a: assert property (confirm_pass
        |=> rpt.valid && rpt.val == $past(buf_r))
        else $error("confirmed value not reported");
    limit_block_a: assert property (confirm_press ##0 (lim_act && !rng_ok)
        |=> !rpt.valid && buf_r == $past(cur_tbl))
        else $error("out of limit value was accepted");
    field_cap_a: assert property (fcnt_r <= MAX_FIELDS)
        else $error("field count above limit");
    thumb_rpt_a: assert property (tw_act |=> rpt.valid
        && rpt.field == $past(cur_r))
        else $error("thumbwheel step not reported");
    thumb_ver_a: assert property (tw_in.valid && !ctrl_r[CTRL_VER5]
        && !conf_act |=> !rpt.valid)
        else $error("thumbwheel active without newer version");
    hex_ignore_a: assert property (is_hexd && !cur_attr.hex && !tw_act
        && !sel_chg |=> buf_r == $past(buf_r))
        else $error("hex key changed a decimal entry");
    sign_flip_a: assert property (entry_ok && k_sign && !tw_act
        && cur_attr.sgn && !cur_attr.hex |=> buf_r.neg != $past(buf_r.neg))
        else $error("sign key did not invert polarity");
endmodule // numeric_entry_key_handler

// >>> dv/host_model.sv
`timescale 1ns/10ps
module host_model
    import entry_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire rpt_s        rpt,
    input  wire key_ev_s     sw_rpt,
    output int               rpt_cnt,
    output int               sw_cnt,
    output val_s             last_val,
    output logic [FLD_W-1:0] last_fld
);
    // The host takes every report at once; it never stalls or refuses one
    always @(posedge clk) begin
        if (!rstn) begin
            rpt_cnt <= 0;
            sw_cnt <= 0;
            last_val <= '0;
            last_fld <= '0;
        end else begin
            if (rpt.valid === 1'b1) begin
                rpt_cnt <= rpt_cnt + 1;
                last_val <= rpt.val;
                last_fld <= rpt.field;
            end
            if (sw_rpt.valid === 1'b1) begin
                sw_cnt <= sw_cnt + 1;
            end
        end
    end
endmodule // host_model

// >>> dv/tb_top.sv
`timescale 1ns/10ps
module tb_top
    import entry_pkg::*;
;
    typedef struct {
        logic [7:0] k;
        logic       sw;
        logic       menu;
    } row_s;

    logic              clk;
    logic              rstn;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
    logic [31:0]       rdata;
    key_ev_s           key_in;
    wheel_ev_s         tw_in;
    logic              buz_start;
    key_ev_s           sw_rpt;
    rpt_s              rpt;
    logic              menu_open;
    logic              buzzer_on;
    logic              keypad_show;
    int                rpt_cnt;
    int                sw_cnt;
    val_s              last_val;
    logic [FLD_W-1:0]  last_fld;
    int                failures;
    int                checked;
    int                n;
    logic              sw_seen;
    logic              menu_seen;
    row_s              rows [7] = '{'{8'h05, 1'b1, 1'b0},
        '{8'hE2, 1'b1, 1'b0}, '{KEY_MENU, 1'b0, 1'b1},
        '{KEY_UP, 1'b0, 1'b0}, '{KEY_DOWN, 1'b0, 1'b0},
        '{KEY_BUZ, 1'b0, 1'b0}, '{KEY_CONFIRM, 1'b0, 1'b0}};

    numeric_entry_key_handler u_numeric_entry_key_handler (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .key_in(key_in), .tw_in(tw_in),
        .buz_start(buz_start), .sw_rpt(sw_rpt), .rpt(rpt),
        .menu_open(menu_open), .buzzer_on(buzzer_on),
        .keypad_show(keypad_show));

    host_model u_host_model (
        .clk(clk), .rstn(rstn), .rpt(rpt), .sw_rpt(sw_rpt),
        .rpt_cnt(rpt_cnt), .sw_cnt(sw_cnt), .last_val(last_val),
        .last_fld(last_fld));

    always #12.5 clk = ~clk;

    task automatic chk(input string what, input logic [32:0] exp,
                       input logic [32:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m = 32'hFFFF_FFFF);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("register", 33'(e & m), 33'(rdata & m));
    endtask

    task automatic press(input logic [7:0] k);
        @(posedge clk);
        key_in <= '{valid: 1'b1, num: k};
        @(posedge clk);
        key_in <= '0;
        #1;
        sw_seen = sw_rpt.valid;
        menu_seen = menu_open;
        @(posedge clk);
        // Let the host model take the report before anyone looks
        #1;
    endtask

    task automatic turn(input logic [2:0] d, input logic up);
        @(posedge clk);
        tw_in <= '{valid: 1'b1, digit: d, up: up};
        @(posedge clk);
        tw_in <= '0;
        @(posedge clk);
        #1;
    endtask

    task automatic digits(input int first, input int count);
        for (int i = 0; i < count; i++) begin
            press(KEY_D0 + 8'(first + i));
        end
    endtask

    task automatic test_done;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // The whole sequence needs well under 2000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end

    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        key_in = '0;
        tw_in = '0;
        buz_start = 1'b0;
        failures = 0;
        checked = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(OFS_CTRL, 32'h0000_0000);
        rd_reg(8'h2C, 32'h0000_0000);
        // No owner yet, so entry keys cannot disturb the table pass
        foreach (rows[i]) begin
            press(rows[i].k);
            chk("switch report", 33'(rows[i].sw), 33'(sw_seen));
            chk("menu pulse", 33'(rows[i].menu), 33'(menu_seen));
        end
        $display("system key test done");
        wr_reg(OFS_CTRL, 32'h0000_000D);
        wr_reg(OFS_OWNER, 32'h0000_0001);
        wr_reg(OFS_OWNER, 32'h0000_0002);
        rd_reg(OFS_OWNER, 32'h0000_0001);
        wr_reg(OFS_FCNT, 32'h0000_0003);
        wr_reg(OFS_SEL, 32'h0000_0001);
        wr_reg(OFS_ATTR, 32'h0000_0002);
        wr_reg(OFS_SEL, 32'h0000_0002);
        wr_reg(OFS_ATTR, 32'h0000_0004);
        wr_reg(OFS_SEL, 32'h0000_0000);
        chk("keypad shown", 33'd1, 33'(keypad_show));
        @(posedge clk);
        buz_start <= 1'b1;
        @(posedge clk);
        buz_start <= 1'b0;
        @(posedge clk);
        #1;
        chk("buzzer on", 33'd1, 33'(buzzer_on));
        press(KEY_BUZ);
        chk("buzzer stopped", 33'd0, 33'(buzzer_on));
        $display("buzzer test done");
        n = rpt_cnt;
        digits(1, 9);
        rd_reg(OFS_BUF, 32'h2345_6789);
        chk("early report", 33'(n), 33'(rpt_cnt));
        press(KEY_HA);
        rd_reg(OFS_BUF, 32'h2345_6789);
        press(KEY_CONFIRM);
        chk("confirm value", {1'b0, 32'h2345_6789}, last_val);
        chk("confirm field", 33'd0, 33'(last_fld));
        rd_reg(OFS_TBL, 32'h2345_6789);
        press(KEY_WIPE);
        rd_reg(OFS_BUF, 32'h0000_0000);
        $display("keypad entry test done");
        press(KEY_UP);
        rd_reg(OFS_STATUS, 32'h0000_0001, 32'h0000_003F);
        digits(1, 8);
        press(KEY_SIGN);
        rd_reg(OFS_BUF, 32'h0234_5678);
        rd_reg(OFS_STATUS, 32'h0000_8000, 32'h0000_8000);
        press(KEY_CONFIRM);
        chk("signed value", {1'b1, 32'h0234_5678}, last_val);
        $display("signed entry test done");
        wr_reg(OFS_UPPER, 32'h0000_0100);
        wr_reg(OFS_CTRL, 32'h0000_000F);
        press(KEY_WIPE);
        digits(1, 3);
        n = rpt_cnt;
        press(KEY_CONFIRM);
        chk("refused report", 33'(n), 33'(rpt_cnt));
        rd_reg(OFS_BUF, 32'h0234_5678);
        wr_reg(OFS_SEL, 32'h0000_0001);
        rd_reg(OFS_TBL, 32'h0234_5678);
        press(KEY_WIPE);
        digits(5, 1);
        digits(0, 1);
        press(KEY_CONFIRM);
        chk("limited value", {1'b0, 32'h0000_0050}, last_val);
        $display("limit test done");
        wr_reg(OFS_CTRL, 32'h0000_000E);
        press(KEY_UP);
        n = rpt_cnt;
        turn(3'd0, 1'b1);
        chk("old protocol", 33'(n), 33'(rpt_cnt));
        wr_reg(OFS_CTRL, 32'h0000_000F);
        turn(3'd0, 1'b1);
        chk("wheel step", {1'b0, 32'h0000_0001}, last_val);
        chk("wheel field", 33'd2, 33'(last_fld));
        turn(3'd2, 1'b1);
        chk("wheel reject", {1'b0, 32'h0000_0001}, last_val);
        chk("wheel reports", 33'(n + 2), 33'(rpt_cnt));
        $display("thumbwheel test done");
        wr_reg(OFS_CTRL, 32'h0000_000D);
        wr_reg(OFS_SEL, 32'h0000_0000);
        wr_reg(OFS_ATTR, 32'h0000_0009);
        press(KEY_HOME);
        press(KEY_WIPE);
        press(KEY_HF);
        press(KEY_HA);
        press(KEY_POINT);
        digits(1, 1);
        rd_reg(OFS_BUF, 32'h0000_0FA1);
        rd_reg(OFS_STATUS, 32'h0000_4400, 32'h0000_7C00);
        press(KEY_CONFIRM);
        chk("hex value", {1'b0, 32'h0000_0FA1}, last_val);
        $display("hex and point test done");
        wr_reg(OFS_FCNT, 32'h0000_003C);
        rd_reg(OFS_FCNT, 32'h0000_0032);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(OFS_CTRL, 32'h0000_0000);
        chk("keypad after reset", 33'd0, 33'(keypad_show));
        $display("register and reset test done");
        test_done();
    end
endmodule // tb_top
